// ==== src/sltt_table.v ====
/*
 * speculative load tracking table: allocation on advanced loads, removal on
 * overlapping stores, re-targeting loads, flushes and capacity; lookup on checks.
 * assumes one operation per cycle from the core pipeline on the same clock,
 * and that the pipeline performs the reissued load on the reload request.
 */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module sltt_table
(
   input wire clock,
   input wire rstn,
   input wire op_valid,
   input wire [`SLTT_OP_W-1:0] op_code,
   input wire [`SLTT_REG_W-1:0] op_reg,
   input wire [`SLTT_ADDR_W-1:0] op_addr,
   input wire [`SLTT_TYPE_W-1:0] op_type,
   input wire [`SLTT_SIZE_W-1:0] op_size,
   input wire op_deferred,
   input wire [`SLTT_PC_W-1:0] op_pc,
   input wire [`SLTT_OFS_W-1:0] op_offset,
   input wire flush,
   output reg chk_done_r,
   output reg chk_hit_r,
   output reg redirect_r,
   output reg [`SLTT_PC_W-1:0] redirect_pc_r,
   output reg reload_r,
   output reg [`SLTT_REG_W-1:0] reload_reg_r,
   output reg [`SLTT_ADDR_W-1:0] reload_addr_r,
   output reg [`SLTT_SIZE_W-1:0] reload_size_r,
   output reg [`SLTT_ENTRIES-1:0] valid_r
);
   // per-entry storage, flip-flops addressed by index
   reg [`SLTT_REG_W-1:0] ent_reg_r [0:`SLTT_ENTRIES-1];
   reg [`SLTT_ADDR_W-1:0] ent_addr_r [0:`SLTT_ENTRIES-1];
   reg [`SLTT_TYPE_W-1:0] ent_type_r [0:`SLTT_ENTRIES-1];
   reg [`SLTT_SIZE_W-1:0] ent_size_r [0:`SLTT_ENTRIES-1];
   reg [`SLTT_IDX_W-1:0] rr_ptr_r;
   reg [`SLTT_IDX_W-1:0] rr_ptr_nxt;
   reg [`SLTT_ENTRIES-1:0] valid_nxt;
   reg [`SLTT_ENTRIES-1:0] keep;
   wire [`SLTT_ENTRIES-1:0] ovl;
   wire [`SLTT_ENTRIES-1:0] reg_match;
   wire [`SLTT_ENTRIES-1:0] type_match;
   wire [`SLTT_IDX_W-1:0] vict_idx;
   wire vict_full;
   wire is_alloc;
   wire is_store;
   wire is_check;
   wire any_hit;
   wire [`SLTT_PC_W-1:0] target_pc;
   integer k;

   // true when the operation allocates; a deferred token on a speculative
   // advanced load means no entry, so the later check misses unless an older entry for that register and type is still valid
   function alloc_op;
      input [`SLTT_OP_W-1:0] code;
      input deferred;
      begin
         alloc_op = (code == `SLTT_OP_ADV_LOAD) ||
            ((code == `SLTT_OP_SPEC_ADV_LOAD) && !deferred);
      end
   endfunction

   assign is_alloc = op_valid && alloc_op(op_code, op_deferred);
   assign is_store = op_valid && (op_code == `SLTT_OP_STORE);
   assign is_check = op_valid && ((op_code == `SLTT_OP_CHECK_RELOAD) ||
      (op_code == `SLTT_OP_CHECK_BRANCH));

   // per-entry comparators
   genvar g;
   generate
      for (g = 0; g < `SLTT_ENTRIES; g = g + 1)
      begin : g_ent
         sltt_overlap u_ovl
         (
            .ent_addr(ent_addr_r[g]),
            .ent_size(ent_size_r[g]),
            .st_addr(op_addr),
            .st_size(op_size),
            .hit(ovl[g])
         );
         assign reg_match[g] = valid_r[g] && (ent_reg_r[g] == op_reg);
         assign type_match[g] = (ent_type_r[g] == op_type);
      end
   endgenerate

   // lookup needs both register and type to match
   assign any_hit = |(reg_match & type_match);

   // recovery target is check address plus the encoded offset
   assign target_pc = op_pc + {{(`SLTT_PC_W-`SLTT_OFS_W){op_offset[`SLTT_OFS_W-1]}},
      op_offset};

   // victim selection among entries left after re-target removal
   sltt_victim u_vict
   (
      .valid(valid_r & ~reg_match),
      .rr_ptr(rr_ptr_r),
      .idx(vict_idx),
      .full(vict_full)
   );

   // next valid vector: removals first, then the new entry
   always @*
   begin
      keep = {`SLTT_ENTRIES{1'b1}};
      valid_nxt = valid_r;
      rr_ptr_nxt = rr_ptr_r;
      if (flush)
      begin
         keep = {`SLTT_ENTRIES{1'b0}};
      end
      else if (is_store)
      begin
         keep = ~ovl;
      end
      else if (is_alloc)
      begin
         keep = ~reg_match;
      end
      valid_nxt = valid_r & keep;
      if (is_alloc && !flush)
      begin
         for (k = 0; k < `SLTT_ENTRIES; k = k + 1)
         begin
            if (vict_idx == k[`SLTT_IDX_W-1:0])
            begin
               valid_nxt[k] = 1'b1;
            end
         end
         if (vict_full)
         begin
            rr_ptr_nxt = rr_ptr_r + 3'h1; // capacity drop
         end
      end
   end

   // entry state and round robin pointer
   always @(posedge clock)
   begin
      if (!rstn)
      begin
         valid_r <= `SLTT_VALID_RST;
         rr_ptr_r <= `SLTT_VICTIM_RST;
      end
      else
      begin
         valid_r <= valid_nxt;
         rr_ptr_r <= rr_ptr_nxt;
      end
   end

   // entry payload written on allocation
   always @(posedge clock)
   begin
      if (is_alloc && !flush)
      begin
         ent_reg_r[vict_idx] <= op_reg;
         ent_addr_r[vict_idx] <= op_addr;
         ent_type_r[vict_idx] <= op_type;
         ent_size_r[vict_idx] <= op_size;
      end
   end

   // check answers, one cycle after the check is taken
   always @(posedge clock)
   begin
      if (!rstn)
      begin
         chk_done_r <= 1'b0;
         chk_hit_r <= 1'b0;
         redirect_r <= 1'b0;
         redirect_pc_r <= {`SLTT_PC_W{1'b0}};
         reload_r <= 1'b0;
         reload_reg_r <= {`SLTT_REG_W{1'b0}};
         reload_addr_r <= {`SLTT_ADDR_W{1'b0}};
         reload_size_r <= {`SLTT_SIZE_W{1'b0}};
      end
      else
      begin
         chk_done_r <= is_check;
         chk_hit_r <= is_check && any_hit;
         redirect_r <= is_check && !any_hit &&
            (op_code == `SLTT_OP_CHECK_BRANCH);
         reload_r <= is_check && !any_hit &&
            (op_code == `SLTT_OP_CHECK_RELOAD);
         if (is_check)
         begin
            redirect_pc_r <= target_pc;
            reload_reg_r <= op_reg;
            reload_addr_r <= op_addr;
            reload_size_r <= op_size;
         end
      end
   end
endmodule // sltt_table

// ==== src/sltt_defs.vh ====
/*
 * constants for the speculative load tracking table: geometry, field widths,
 * operation codes, load types and the reset values.
 * assumes the including file uses these names unqualified.
 */
// Operation
// - an advanced load allocates a fresh table entry.
// - entries keyed by target register; hold address, load type, access size.
// - check searches for register and type match; hit continues with next instruction.
// - failed branching check transfers control to the recovery target it carries.
// - failed check-reload reissues the load and writes the target register.
// - branching check encodes a register number and a recovery offset.
// - a store overlapping an entry's recorded address removes that entry.
// - new advanced load to an existing entry's register removes the old entry.
// - implementation conditions may flush entries to keep results correct.
// - capacity or matching limits may drop entries; later checks then miss.
// - speculative advanced load producing a deferred token allocates nothing.
// - with no free entry, an existing entry may be invalidated for the new one.
`ifndef SLTT_DEFS_VH
`define SLTT_DEFS_VH

// table geometry
`define SLTT_ENTRIES 8
`define SLTT_IDX_W 3
`define SLTT_REG_W 7
`define SLTT_ADDR_W 64
`define SLTT_TYPE_W 2
`define SLTT_SIZE_W 2
`define SLTT_OFS_W 21
`define SLTT_PC_W 64

// operation codes from the pipeline
`define SLTT_OP_W 3
`define SLTT_OP_NONE 3'h0
`define SLTT_OP_ADV_LOAD 3'h1
`define SLTT_OP_SPEC_ADV_LOAD 3'h2
`define SLTT_OP_STORE 3'h3
`define SLTT_OP_CHECK_RELOAD 3'h4
`define SLTT_OP_CHECK_BRANCH 3'h5

// load types recorded per entry
`define SLTT_TYPE_INT 2'h0
`define SLTT_TYPE_FP 2'h1

// reset values
`define SLTT_VALID_RST 8'h00
`define SLTT_VICTIM_RST 3'h0

`endif

// ==== src/sltt_overlap.v ====
/*
 * byte range overlap comparator: one entry against one store.
 * assumes sizes encode 1, 2, 4 or 8 bytes as log2 and ranges do not wrap.
 */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module sltt_overlap
(
   input wire [`SLTT_ADDR_W-1:0] ent_addr,
   input wire [`SLTT_SIZE_W-1:0] ent_size,
   input wire [`SLTT_ADDR_W-1:0] st_addr,
   input wire [`SLTT_SIZE_W-1:0] st_size,
   output wire hit
);
   wire [`SLTT_ADDR_W-1:0] ent_end;
   wire [`SLTT_ADDR_W-1:0] st_end;

   // last byte of each range, then interval intersection
   assign ent_end = ent_addr + ({{(`SLTT_ADDR_W-1){1'b0}}, 1'b1} << ent_size) - 64'h1;
   assign st_end = st_addr + ({{(`SLTT_ADDR_W-1){1'b0}}, 1'b1} << st_size) - 64'h1;
   assign hit = (st_addr <= ent_end) && (ent_addr <= st_end);
endmodule // sltt_overlap

// ==== src/sltt_victim.v ====
/*
 * victim chooser: lowest free entry, else a round robin pointer.
 * assumes the caller advances the pointer when a full-table allocation occurs.
 */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module sltt_victim
(
   input wire [`SLTT_ENTRIES-1:0] valid,
   input wire [`SLTT_IDX_W-1:0] rr_ptr,
   output reg [`SLTT_IDX_W-1:0] idx,
   output reg full
);
   integer i;

   // priority search for an unused entry
   always @*
   begin
      idx = rr_ptr;
      full = 1'b1;
      for (i = `SLTT_ENTRIES - 1; i >= 0; i = i - 1)
      begin
         if (!valid[i])
         begin
            idx = i[`SLTT_IDX_W-1:0];
            full = 1'b0;
         end
      end
   end
endmodule // sltt_victim

// ==== verification/sltt_table_checker.sv ====
/* port assertions for the load tracking table.
   assumes it is bound onto sltt_table and shares its clock and reset. */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module sltt_table_checker
(
   input wire clock,
   input wire rstn,
   input wire op_valid,
   input wire [`SLTT_OP_W-1:0] op_code,
   input wire [`SLTT_REG_W-1:0] op_reg,
   input wire [`SLTT_ADDR_W-1:0] op_addr,
   input wire op_deferred,
   input wire [`SLTT_PC_W-1:0] op_pc,
   input wire [`SLTT_OFS_W-1:0] op_offset,
   input wire flush,
   input wire chk_done_r,
   input wire chk_hit_r,
   input wire redirect_r,
   input wire [`SLTT_PC_W-1:0] redirect_pc_r,
   input wire reload_r,
   input wire [`SLTT_REG_W-1:0] reload_reg_r,
   input wire [`SLTT_ADDR_W-1:0] reload_addr_r,
   input wire [`SLTT_ENTRIES-1:0] valid_r
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // decoded operation classes of the current cycle
   wire go = op_valid && !flush;
   wire is_chk = go && (op_code == `SLTT_OP_CHECK_RELOAD || op_code == `SLTT_OP_CHECK_BRANCH);
   sequence chk_miss;
      chk_done_r && !chk_hit_r;
   endsequence
   // every check answered next cycle, nothing else answered
   check_answer_a: assert property (is_chk |=> chk_done_r) else $error("check unanswered");
   no_stray_a: assert property (!is_chk |=> !chk_done_r) else $error("stray answer");
   miss_action_a: assert property (chk_miss |-> redirect_r != reload_r) else $error("bad miss");
   redirect_target_a: assert property (redirect_r |-> redirect_pc_r == $past(op_pc)
      + {{43{$past(op_offset[20])}}, $past(op_offset)}) else $error("bad recovery target");
   reload_info_a: assert property (reload_r |-> !redirect_r && reload_reg_r == $past(op_reg)
      && reload_addr_r == $past(op_addr)) else $error("bad reload details");
   reset_clear_a: assert property ($rose(rstn) |-> valid_r == 8'h00) else $error("reset kept");
   flush_clear_a: assert property (flush |=> valid_r == 8'h00) else $error("flush kept");
   alloc_entry_a: assert property (go && op_code == `SLTT_OP_ADV_LOAD |=> valid_r != 8'h00)
      else $error("no allocation");
   deferred_none_a: assert property (go && op_code == `SLTT_OP_SPEC_ADV_LOAD && op_deferred
      |=> $countones(valid_r) <= $countones($past(valid_r))) else $error("deferred allocated");
   empty_miss_a: assert property (is_chk && valid_r == 8'h00 |=> !chk_hit_r)
      else $error("hit on empty table");
endmodule // sltt_table_checker
bind sltt_table sltt_table_checker chk_i(.clock, .rstn, .op_valid, .op_code, .op_reg, .op_addr,
   .op_deferred, .op_pc, .op_offset, .flush, .chk_done_r, .chk_hit_r, .redirect_r,
   .redirect_pc_r, .reload_r, .reload_reg_r, .reload_addr_r, .valid_r);

// ==== verification/sltt_pipe.sv ====
/* pipeline model: issues one operation, holds it one cycle, then releases it.
   assumes the table's clock; code seven stands for a flush cycle. */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module sltt_pipe
(
   input wire clock,
   output reg op_valid,
   output reg [`SLTT_OP_W-1:0] op_code,
   output reg [`SLTT_REG_W-1:0] op_reg,
   output reg [`SLTT_ADDR_W-1:0] op_addr,
   output reg [`SLTT_TYPE_W-1:0] op_type,
   output reg [`SLTT_SIZE_W-1:0] op_size,
   output reg op_deferred,
   output reg [`SLTT_PC_W-1:0] op_pc,
   output reg [`SLTT_OFS_W-1:0] op_offset,
   output reg flush
);
   // idle lines, fixed check address and backward recovery offset
   initial
   begin
      {op_valid, op_code, op_reg, op_addr, op_type, op_size, op_deferred, flush} = 0;
      op_pc = 64'h1000;
      op_offset = 21'h1ffff0;
   end
   // callers check on the load's own register, release inverts the held address
   task issue(input [2:0] c, input [6:0] r, input [63:0] a, input [1:0] t, s, input d);
      begin
         @(negedge clock);
         flush = (c == 3'h7);
         op_valid = !flush;
         {op_code, op_reg, op_addr, op_type, op_size, op_deferred} = {c, r, a, t, s, d};
         @(negedge clock);
         op_valid = 1'b0;
         flush = 1'b0;
         op_addr = ~op_addr;
      end
   endtask
endmodule // sltt_pipe

// ==== verification/advanced_load_tracking_table_test.sv ====
/* self-checking bench for the load tracking table.
   assumes the pipeline model drives every operation input. */
`timescale 1ns/1ps
`include "sltt_defs.vh"
module advanced_load_tracking_table_test;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   integer n_errors = 0;
   integer cmp_count = 0;
   integer i;
   wire op_valid, op_deferred, flush, chk_done_r, chk_hit_r, redirect_r, reload_r;
   wire [2:0] op_code;
   wire [6:0] op_reg, reload_reg_r;
   wire [1:0] op_type, op_size, reload_size_r;
   wire [63:0] op_addr, op_pc, redirect_pc_r, reload_addr_r;
   wire [20:0] op_offset;
   wire [7:0] valid_r;
   sltt_pipe pipe(.clock, .op_valid, .op_code, .op_reg, .op_addr, .op_type, .op_size,
      .op_deferred, .op_pc, .op_offset, .flush);
   sltt_table dut(.clock, .rstn, .op_valid, .op_code, .op_reg, .op_addr, .op_type, .op_size,
      .op_deferred, .op_pc, .op_offset, .flush, .chk_done_r, .chk_hit_r, .redirect_r,
      .redirect_pc_r, .reload_r, .reload_reg_r, .reload_addr_r, .reload_size_r, .valid_r);
   // clock and watchdog
   always #20 clock = ~clock;
   initial
   begin
      #200000;
      n_errors = n_errors + 1;
      conclude;
   end
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // answer flags as done, hit, reload, redirect
   task op(input [2:0] c, input [6:0] r, input [63:0] a, input [1:0] t, input d);
      pipe.issue(c, r, a, t, 2'h3, d);
   endtask
   task t_reset_miss;
      begin
         chk(valid_r, 0);
         op(`SLTT_OP_CHECK_RELOAD, 7'h05, 64'h200, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'ha);
         chk(reload_addr_r, 64'h200);
         chk({reload_reg_r, reload_size_r}, {7'h05, 2'h3});
      end
   endtask
   task t_hit_type;
      begin
         op(`SLTT_OP_ADV_LOAD, 7'h05, 64'h100, 2'h0, 1'b0);
         chk($countones(valid_r), 1);
         op(`SLTT_OP_CHECK_RELOAD, 7'h05, 64'h100, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'hc);
         op(`SLTT_OP_CHECK_RELOAD, 7'h05, 64'h100, 2'h1, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'ha);
      end
   endtask
   task t_store_branch;
      begin
         op(`SLTT_OP_ADV_LOAD, 7'h09, 64'h100, 2'h0, 1'b0);
         pipe.issue(`SLTT_OP_STORE, 7'h00, 64'h108, 2'h0, 2'h0, 1'b0);
         chk($countones(valid_r), 2);
         pipe.issue(`SLTT_OP_STORE, 7'h00, 64'h107, 2'h0, 2'h0, 1'b0);
         chk(valid_r, 0);
         op(`SLTT_OP_CHECK_BRANCH, 7'h09, 64'h0, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'h9);
         chk(redirect_pc_r, 64'hff0);
      end
   endtask
   task t_retarget;
      begin
         op(`SLTT_OP_ADV_LOAD, 7'h03, 64'h40, 2'h0, 1'b0);
         op(`SLTT_OP_ADV_LOAD, 7'h03, 64'h80, 2'h0, 1'b0);
         op(`SLTT_OP_STORE, 7'h00, 64'h40, 2'h0, 1'b0);
         op(`SLTT_OP_CHECK_RELOAD, 7'h03, 64'h80, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, $countones(valid_r)}, 34'h300000001);
         op(`SLTT_OP_SPEC_ADV_LOAD, 7'h04, 64'h300, 2'h0, 1'b1);
         chk($countones(valid_r), 1);
         op(`SLTT_OP_SPEC_ADV_LOAD, 7'h04, 64'h300, 2'h0, 1'b0);
         chk($countones(valid_r), 2);
         op(`SLTT_OP_CHECK_BRANCH, 7'h04, 64'h0, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'hc);
      end
   endtask
   task t_capacity;
      begin
         op(3'h7, 7'h00, 64'h0, 2'h0, 1'b0);
         chk(valid_r, 0);
         for (i = 0; i < 9; i = i + 1)
            op(`SLTT_OP_ADV_LOAD, 7'h10 + i[6:0], 64'h1000 + 16 * i, 2'h0, 1'b0);
         chk(valid_r, 8'hff);
         op(`SLTT_OP_CHECK_RELOAD, 7'h10, 64'h1000, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'ha);
         op(`SLTT_OP_CHECK_RELOAD, 7'h18, 64'h1080, 2'h0, 1'b0);
         chk({chk_done_r, chk_hit_r, reload_r, redirect_r}, 4'hc);
      end
   endtask
   task do_reset;
      begin
         rstn = 1'b0;
         repeat (16) @(negedge clock);
         rstn = 1'b1;
      end
   endtask
   task conclude;
      begin
         $display("errors=%0d compares=%0d", n_errors, cmp_count);
         if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // main sequence, with a second reset over a filled table
   initial
   begin
      do_reset;
      t_reset_miss;
      t_hit_type;
      t_store_branch;
      t_retarget;
      t_capacity;
      do_reset;
      t_reset_miss;
      conclude;
   end
endmodule // advanced_load_tracking_table_test
